// file: rtl/pfr_pkg.sv
`default_nettype none
package pfr_pkg;
    // Sizes
    localparam int NPORT = 4;
    localparam int PORT_W = 2;
    localparam int DLY_W = 16;
    localparam int CF_W = 32;
    localparam int SEQ_W = 16;
    localparam int SEQ_N = 256;
    localparam int SEQ_IW = 8;
    localparam int MAC_W = 48;
    localparam int STAMP_W = 32;
    localparam int FIFO_D = 8;
    localparam int DOM_W = 2;
    localparam int MODE_W = 2;
    localparam int DM_W = DOM_W + MODE_W;
    localparam int ACT_W = 8;
    //////////////////////////////////////////////////////////////////////
    // Action code field positions
    localparam int ACT_PTP_LSB = 0;
    localparam int ACT_DLY_LSB = 2;
    localparam int ACT_SEQ_LSB = 4;
    localparam int ACT_S2D_BIT = 6;
    localparam int ACT_CSA_BIT = 7;
    //////////////////////////////////////////////////////////////////////
    // Command codes
    localparam logic [1:0] PTP_NOP = 2'h0;
    localparam logic [1:0] PTP_ONE = 2'h1;
    localparam logic [1:0] PTP_TWO = 2'h2;
    localparam logic [1:0] PTP_TOD = 2'h3;
    localparam logic [1:0] DLY_NONE = 2'h0;
    localparam logic [1:0] DLY_EGR = 2'h1;
    localparam logic [1:0] DLY_IGR_A = 2'h2;
    localparam logic [1:0] DLY_IGR_B = 2'h3;
    localparam logic [1:0] SEQ_NOP = 2'h0;
    localparam logic [1:0] SEQ_UPD = 2'h1;
    //////////////////////////////////////////////////////////////////////
    // Reset values and record layout
    localparam logic [SEQ_W-1:0] SEQ_RST = 16'h0000;
    localparam int FLG_W = 3;
    localparam int REC_W = 2 * MAC_W + SEQ_W + CF_W + DM_W + FLG_W;
endpackage : pfr_pkg
`default_nettype wire

// file: rtl/pfr_fifo.sv
`default_nettype none
module pfr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Fill side
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    // Drain side
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data
);
    // Pointers wrap naturally, so DEPTH must be a power of two
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic wr;
    logic rd;

    assign wr = i_wr_valid & o_wr_ready;
    assign rd = o_rd_valid & i_rd_ready;
    assign cnt_nxt = cnt_r + (AW + 1)'(wr) - (AW + 1)'(rd);
    assign o_rd_data = mem_r[rp_r];

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            o_rd_valid <= 1'b0;
            o_wr_ready <= 1'b1;
        end else begin
            if (wr) begin
                wp_r <= wp_r + AW'(1);
            end
            if (rd) begin
                rp_r <= rp_r + AW'(1);
            end
            cnt_r <= cnt_nxt;
            o_rd_valid <= cnt_nxt != '0;
            o_wr_ready <= cnt_nxt != FULL;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (wr) begin
            mem_r[wp_r] <= i_wr_data;
        end
    end
endmodule : pfr_fifo
`default_nettype wire

// file: rtl/pfr_seq_table.sv
`default_nettype none
module pfr_seq_table (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Hardware read and increment
    input wire logic i_inc,
    input wire logic [pfr_pkg::SEQ_IW-1:0] i_inc_idx,
    output logic [pfr_pkg::SEQ_W-1:0] o_inc_val,
    // Software set or get
    input wire logic i_sw_wr,
    input wire logic [pfr_pkg::SEQ_IW-1:0] i_sw_idx,
    input wire logic [pfr_pkg::SEQ_W-1:0] i_sw_wdata,
    output logic [pfr_pkg::SEQ_W-1:0] o_sw_rdata
);
    localparam int IW = pfr_pkg::SEQ_IW;
    localparam int SW = pfr_pkg::SEQ_W;

    logic [SW-1:0] tab_r [pfr_pkg::SEQ_N];

    assign o_inc_val = tab_r[i_inc_idx];

    // Software write wins over a same-entry increment
    for (genvar g = 0; g < pfr_pkg::SEQ_N; g++) begin : g_ent
        always_ff @(posedge i_ref_clk) begin
            if (i_rst) begin
                tab_r[g] <= pfr_pkg::SEQ_RST;
            end else if (i_sw_wr && i_sw_idx == IW'(g)) begin
                tab_r[g] <= i_sw_wdata;
            end else if (i_inc && i_inc_idx == IW'(g)) begin
                tab_r[g] <= tab_r[g] + SW'(1);
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_sw_rdata <= pfr_pkg::SEQ_RST;
        end else begin
            o_sw_rdata <= tab_r[i_sw_idx];
        end
    end
endmodule : pfr_seq_table
`default_nettype wire

// file: rtl/pfr_rewriter.sv
`default_nettype none
module pfr_rewriter (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Frames from switch core
    input wire logic i_frm_valid,
    output logic o_frm_ready,
    input wire logic [pfr_pkg::ACT_W-1:0] i_rewrite_action_code,
    input wire logic [pfr_pkg::PORT_W-1:0] i_frm_tx_port,
    input wire logic [pfr_pkg::PORT_W-1:0] i_frm_rx_port,
    input wire logic i_frm_cpu_port,
    input wire logic [pfr_pkg::SEQ_IW-1:0] i_internal_frame_header_ts,
    input wire logic [pfr_pkg::MAC_W-1:0] i_frm_dmac,
    input wire logic [pfr_pkg::MAC_W-1:0] i_frm_smac,
    input wire logic [pfr_pkg::SEQ_W-1:0] i_frm_seq,
    input wire logic [pfr_pkg::CF_W-1:0] i_frm_cf,
    input wire logic [pfr_pkg::CF_W-1:0] i_frm_rx_time,
    input wire logic [pfr_pkg::STAMP_W-1:0] i_frm_stamp,
    input wire logic i_frm_rsv_nz,
    // Frames to link
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [pfr_pkg::MAC_W-1:0] o_out_dmac,
    output logic [pfr_pkg::MAC_W-1:0] o_out_smac,
    output logic [pfr_pkg::SEQ_W-1:0] o_out_seq,
    output logic [pfr_pkg::CF_W-1:0] o_out_cf,
    output logic [pfr_pkg::DM_W-1:0] o_out_domain_mode,
    output logic [pfr_pkg::FLG_W-1:0] o_out_flags,
    // Rewriter configuration
    input wire logic [pfr_pkg::NPORT-1:0][pfr_pkg::DM_W-1:0]
        i_port_domain_mode_cfg,
    input wire logic [pfr_pkg::DM_W-1:0] i_cpu_vport_domain_mode_cfg,
    input wire logic [pfr_pkg::NPORT-1:0][pfr_pkg::DLY_W-1:0]
        i_egress_opt_delay,
    input wire logic [pfr_pkg::NPORT-1:0][pfr_pkg::DLY_W-1:0]
        i_ingress_opt_delay_a,
    input wire logic [pfr_pkg::NPORT-1:0][pfr_pkg::DLY_W-1:0]
        i_ingress_opt_delay_b,
    input wire logic [pfr_pkg::NPORT-1:0][31:0] i_timing_src_addr_low,
    input wire logic [pfr_pkg::NPORT-1:0][15:0] i_timing_src_addr_high,
    input wire logic [pfr_pkg::NPORT-1:0] i_checksum_update_ctrl,
    // Sequence table access
    input wire logic i_seq_wr,
    input wire logic [pfr_pkg::SEQ_IW-1:0] i_seq_idx,
    input wire logic [pfr_pkg::SEQ_W-1:0] i_seq_wdata,
    output logic [pfr_pkg::SEQ_W-1:0] o_flow_sequence_table,
    // Two-step stamp queue
    input wire logic i_stamp_fifo_ctrl,
    output logic [pfr_pkg::STAMP_W-1:0] o_stamp_fifo_value,
    output logic o_stamp_fifo_valid,
    output logic o_stamp_drop_sticky,
    input wire logic i_stamp_drop_clr,
    // Port module configuration
    input wire logic [pfr_pkg::NPORT-1:0] i_port_timing_ena,
    input wire logic [pfr_pkg::NPORT-1:0][pfr_pkg::DLY_W-1:0]
        i_rx_io_delay,
    input wire logic [pfr_pkg::NPORT-1:0][pfr_pkg::DLY_W-1:0]
        i_tx_io_delay,
    input wire logic [pfr_pkg::NPORT-1:0][pfr_pkg::DOM_W-1:0]
        i_port_timing_domain,
    // Sticky flags
    output logic o_reserved_field_sticky,
    input wire logic i_reserved_field_clr,
    output logic [pfr_pkg::NPORT-1:0] o_correction_overflow_sticky,
    input wire logic [pfr_pkg::NPORT-1:0] i_correction_overflow_clr
);
    localparam int CW = pfr_pkg::CF_W;
    localparam int MW = pfr_pkg::MODE_W;

    //////////////////////////////////////////////////////////////////////
    // Action decode
    logic [1:0] ptp_cmd;
    logic [1:0] dly_cmd;
    logic [1:0] seq_cmd;
    logic take;
    logic in_rdy_r;
    logic [pfr_pkg::DM_W-1:0] dm_sel;
    logic ena;

    assign ptp_cmd = i_rewrite_action_code[pfr_pkg::ACT_PTP_LSB +: 2];
    assign dly_cmd = i_rewrite_action_code[pfr_pkg::ACT_DLY_LSB +: 2];
    assign seq_cmd = i_rewrite_action_code[pfr_pkg::ACT_SEQ_LSB +: 2];
    assign take = i_frm_valid & in_rdy_r;
    assign o_frm_ready = in_rdy_r;
    // CPU and virtual ports carry their own setting
    assign dm_sel = i_frm_cpu_port ? i_cpu_vport_domain_mode_cfg
                                   : i_port_domain_mode_cfg[i_frm_tx_port];
    // Port module only rewrites frames of its own domain
    assign ena = i_port_timing_ena[i_frm_tx_port] &&
                 i_port_timing_domain[i_frm_tx_port] == dm_sel[pfr_pkg::DM_W-1:MW];

    //////////////////////////////////////////////////////////////////////
    // Correction field
    logic [pfr_pkg::DLY_W-1:0] opt_dly;
    logic [CW:0] cf_sum;
    logic [CW-1:0] rx_line;
    logic [CW-1:0] cf_nxt;
    logic ovf;

    always_comb begin
        case (dly_cmd)
            pfr_pkg::DLY_EGR: opt_dly = i_egress_opt_delay[i_frm_tx_port];
            pfr_pkg::DLY_IGR_A: opt_dly = i_ingress_opt_delay_a[i_frm_rx_port];
            pfr_pkg::DLY_IGR_B: opt_dly = i_ingress_opt_delay_b[i_frm_rx_port];
            default: opt_dly = '0;
        endcase
    end

    assign cf_sum = {1'b0, i_frm_cf} + (CW + 1)'(opt_dly)
                  + (CW + 1)'(i_tx_io_delay[i_frm_tx_port]);
    assign rx_line = i_frm_rx_time - CW'(i_rx_io_delay[i_frm_rx_port]);

    // Two-step and time-of-day frames keep their field untouched
    always_comb begin
        cf_nxt = i_frm_cf;
        ovf = 1'b0;
        if (ena && ptp_cmd == pfr_pkg::PTP_ONE) begin
            if (seq_cmd[1]) begin
                cf_nxt = rx_line;
            end else begin
                cf_nxt = cf_sum[CW-1:0];
                ovf = cf_sum[CW];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Sequence table
    logic seq_inc;
    logic [pfr_pkg::SEQ_W-1:0] seq_hw;

    assign seq_inc = take && ena && seq_cmd == pfr_pkg::SEQ_UPD;

    pfr_seq_table u_seq (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_inc(seq_inc),
        .i_inc_idx(i_internal_frame_header_ts),
        .o_inc_val(seq_hw),
        .i_sw_wr(i_seq_wr),
        .i_sw_idx(i_seq_idx),
        .i_sw_wdata(i_seq_wdata),
        .o_sw_rdata(o_flow_sequence_table)
    );

    //////////////////////////////////////////////////////////////////////
    // Address rewrite and flags
    logic [pfr_pkg::MAC_W-1:0] cfg_smac;
    logic s2d;
    logic csa;
    logic modified;
    logic [pfr_pkg::FLG_W-1:0] flg_nxt;

    assign cfg_smac = {i_timing_src_addr_high[i_frm_tx_port],
                       i_timing_src_addr_low[i_frm_tx_port]};
    assign s2d = ena && i_rewrite_action_code[pfr_pkg::ACT_S2D_BIT];
    assign csa = ena && i_rewrite_action_code[pfr_pkg::ACT_CSA_BIT];
    assign modified = ptp_cmd == pfr_pkg::PTP_ONE || s2d || csa ||
                      seq_cmd == pfr_pkg::SEQ_UPD;
    // Checksum update, automatic response, time-of-day stamp
    assign flg_nxt = {ena && modified && !i_checksum_update_ctrl[i_frm_tx_port],
                      ena && seq_cmd[1],
                      ena && ptp_cmd == pfr_pkg::PTP_TOD};

    //////////////////////////////////////////////////////////////////////
    // Stage register ahead of the output queue
    logic st_vld_r;
    logic st_vld_nxt;
    logic q_rdy;
    logic [pfr_pkg::MAC_W-1:0] st_dmac_r;
    logic [pfr_pkg::MAC_W-1:0] st_smac_r;
    logic [pfr_pkg::SEQ_W-1:0] st_seq_r;
    logic [CW-1:0] st_cf_r;
    logic [pfr_pkg::DM_W-1:0] st_dm_r;
    logic [pfr_pkg::FLG_W-1:0] st_flg_r;

    // Half rate on purpose: ready stays a plain flop
    assign st_vld_nxt = take | (st_vld_r & ~q_rdy);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_vld_r <= 1'b0;
            in_rdy_r <= 1'b1;
        end else begin
            st_vld_r <= st_vld_nxt;
            in_rdy_r <= ~st_vld_nxt;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_dmac_r <= '0;
            st_smac_r <= '0;
            st_seq_r <= '0;
            st_cf_r <= '0;
            st_dm_r <= '0;
            st_flg_r <= '0;
        end else if (take) begin
            st_dmac_r <= s2d ? i_frm_smac : i_frm_dmac;
            st_smac_r <= csa ? cfg_smac : i_frm_smac;
            st_seq_r <= seq_inc ? seq_hw : i_frm_seq;
            st_cf_r <= cf_nxt;
            st_dm_r <= dm_sel;
            st_flg_r <= flg_nxt;
        end
    end

    pfr_fifo #(.WIDTH(pfr_pkg::REC_W), .DEPTH(pfr_pkg::FIFO_D)) u_outq (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_wr_valid(st_vld_r),
        .o_wr_ready(q_rdy),
        .i_wr_data({st_dmac_r, st_smac_r, st_seq_r, st_cf_r, st_dm_r,
                    st_flg_r}),
        .o_rd_valid(o_out_valid),
        .i_rd_ready(i_out_ready),
        .o_rd_data({o_out_dmac, o_out_smac, o_out_seq, o_out_cf,
                    o_out_domain_mode, o_out_flags})
    );

    //////////////////////////////////////////////////////////////////////
    // Two-step stamp queue
    logic stamp_push;
    logic stamp_rdy;
    logic stamp_vld;
    logic [pfr_pkg::STAMP_W-1:0] stamp_head;

    assign stamp_push = take && ena && ptp_cmd == pfr_pkg::PTP_TWO;

    pfr_fifo #(.WIDTH(pfr_pkg::STAMP_W), .DEPTH(pfr_pkg::FIFO_D)) u_stq (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_wr_valid(stamp_push),
        .o_wr_ready(stamp_rdy),
        .i_wr_data(i_frm_stamp),
        .o_rd_valid(stamp_vld),
        .i_rd_ready(i_stamp_fifo_ctrl),
        .o_rd_data(stamp_head)
    );

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_stamp_fifo_value <= '0;
            o_stamp_fifo_valid <= 1'b0;
        end else begin
            // Empty queue shows zero, never unwritten storage
            o_stamp_fifo_value <= stamp_vld ? stamp_head : '0;
            o_stamp_fifo_valid <= stamp_vld;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Sticky flags: a set in the clearing cycle wins
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_stamp_drop_sticky <= 1'b0;
        end else if (stamp_push && !stamp_rdy) begin
            o_stamp_drop_sticky <= 1'b1;
        end else if (i_stamp_drop_clr) begin
            o_stamp_drop_sticky <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_reserved_field_sticky <= 1'b0;
        end else if (take && ptp_cmd != pfr_pkg::PTP_NOP && i_frm_rsv_nz) begin
            o_reserved_field_sticky <= 1'b1;
        end else if (i_reserved_field_clr) begin
            o_reserved_field_sticky <= 1'b0;
        end
    end

    for (genvar g = 0; g < pfr_pkg::NPORT; g++) begin : g_ovf
        always_ff @(posedge i_ref_clk) begin
            if (i_rst) begin
                o_correction_overflow_sticky[g] <= 1'b0;
            end else if (take && ovf &&
                         i_frm_tx_port == pfr_pkg::PORT_W'(g)) begin
                o_correction_overflow_sticky[g] <= 1'b1;
            end else if (i_correction_overflow_clr[g]) begin
                o_correction_overflow_sticky[g] <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    a_dmac_copy: assert property (take && s2d |=>
        st_dmac_r == $past(i_frm_smac)) else $error("dmac not copied");
    a_smac_cfg: assert property (take && csa |=>
        st_smac_r == $past(cfg_smac)) else $error("smac not replaced");
    a_seq_update: assert property (seq_inc |=>
        st_seq_r == $past(seq_hw) && (seq_hw == $past(seq_hw) + 16'h1
        || $past(i_seq_wr) || $changed(i_internal_frame_header_ts)))
        else $error("sequence not used or bumped");
    a_two_step_cf: assert property (take && ptp_cmd == pfr_pkg::PTP_TWO |=>
        st_cf_r == $past(i_frm_cf)) else $error("two-step cf changed");
    a_rx_time_cf: assert property (take && ena && seq_cmd[1] &&
        ptp_cmd == pfr_pkg::PTP_ONE |=> st_cf_r == $past(rx_line))
        else $error("cf not reception time");
    a_csum_off: assert property (take && i_checksum_update_ctrl[i_frm_tx_port]
        |=> !st_flg_r[2]) else $error("checksum update not disabled");
    a_stamp_queue: assert property (stamp_push && stamp_rdy |-> ##2
        o_stamp_fifo_valid) else $error("stamp not presented");
    a_rsv_set: assert property (take && i_frm_rsv_nz &&
        ptp_cmd != pfr_pkg::PTP_NOP |=> o_reserved_field_sticky [*2] or
        ##1 $past(i_reserved_field_clr)) else $error("reserved flag lost");
    a_sticky_hold: assert property (o_reserved_field_sticky &&
        !i_reserved_field_clr |=> o_reserved_field_sticky)
        else $error("reserved flag dropped");
    a_ovf_set: assert property (take && ovf |=>
        o_correction_overflow_sticky[$past(i_frm_tx_port)])
        else $error("overflow flag not set");
endmodule : pfr_rewriter
`default_nettype wire

// file: bench/pfr_link_partner.sv
`default_nettype none
module pfr_link_partner (
    // Clock
    input wire logic i_ref_clk,
    // Pacing control
    input wire logic i_stall,
    output logic o_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    // Random gaps so the output queue does not always drain at full rate
    initial begin
        o_ready = 1'b0;
    end
    always @(posedge i_ref_clk) begin
        o_ready <= #1 !i_stall && ($urandom % 4 != 0);
    end
endmodule : pfr_link_partner
`default_nettype wire

// file: bench/pfr_rewriter_tb_top.sv
`default_nettype none
module pfr_rewriter_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [47:0] d;
        logic [47:0] s;
        logic [15:0] q;
        logic [31:0] c;
        logic [3:0] m;
        logic [2:0] f;
    } pfr_exp_t;
    typedef logic [3:0][15:0] pfr_dly_t;
    logic clk, rst, fv, fr, cpu, rz, ov, ordy, stall;
    logic [7:0] act, ts, seq_idx;
    logic [1:0] tx, rx;
    logic [47:0] dm, sm, od, os;
    logic [15:0] sq, oq, seq_wd, seq_rd;
    logic [31:0] cf, rt, st, oc, sval;
    logic [3:0] odm, cpucfg, ena, ck, ovs, ovclr, ov_e;
    logic [2:0] of;
    logic [3:0][3:0] pdm;
    logic [3:0][1:0] pdom;
    logic [3:0][31:0] lo;
    logic [3:0][15:0] hi;
    pfr_dly_t egr, iga, igb, rxio, txio;
    logic seq_wr, spop, svld, sdrop, rsts, rclr, rsv_e;
    logic [15:0] tbl [256];
    pfr_exp_t ex[$];
    pfr_exp_t me;
    logic [31:0] stq[$];
    int err_count, total_checks, i, dv;
    logic [1:0] dom;
    ////////////////////////////////////////////////////////////////////////
    pfr_rewriter i_dut (.i_ref_clk(clk), .i_rst(rst), .i_frm_valid(fv),
        .o_frm_ready(fr), .i_rewrite_action_code(act), .i_frm_tx_port(tx),
        .i_frm_rx_port(rx), .i_frm_cpu_port(cpu),
        .i_internal_frame_header_ts(ts), .i_frm_dmac(dm), .i_frm_smac(sm),
        .i_frm_seq(sq), .i_frm_cf(cf), .i_frm_rx_time(rt), .i_frm_stamp(st),
        .i_frm_rsv_nz(rz), .o_out_valid(ov), .i_out_ready(ordy),
        .o_out_dmac(od), .o_out_smac(os), .o_out_seq(oq), .o_out_cf(oc),
        .o_out_domain_mode(odm), .o_out_flags(of),
        .i_port_domain_mode_cfg(pdm), .i_cpu_vport_domain_mode_cfg(cpucfg),
        .i_egress_opt_delay(egr), .i_ingress_opt_delay_a(iga),
        .i_ingress_opt_delay_b(igb), .i_timing_src_addr_low(lo),
        .i_timing_src_addr_high(hi), .i_checksum_update_ctrl(ck),
        .i_seq_wr(seq_wr), .i_seq_idx(seq_idx), .i_seq_wdata(seq_wd),
        .o_flow_sequence_table(seq_rd), .i_stamp_fifo_ctrl(spop),
        .o_stamp_fifo_value(sval), .o_stamp_fifo_valid(svld),
        .o_stamp_drop_sticky(sdrop), .i_stamp_drop_clr(1'b0),
        .i_port_timing_ena(ena), .i_rx_io_delay(rxio), .i_tx_io_delay(txio),
        .i_port_timing_domain(pdom), .o_reserved_field_sticky(rsts),
        .i_reserved_field_clr(rclr), .o_correction_overflow_sticky(ovs),
        .i_correction_overflow_clr(ovclr));
    pfr_link_partner i_lp (.i_ref_clk(clk), .i_stall(stall), .o_ready(ordy));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [63:0] e, s);
        total_checks++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            err_count++;
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    // z[0] marks a reserved field, z[1] forces a correction near wrap
    task automatic send(input logic [7:0] a, input logic [1:0] t, r,
                        input logic c, input logic [1:0] z);
        pfr_exp_t e;
        logic [3:0] m;
        logic [32:0] sum;
        logic [15:0] opt;
        @(posedge clk);
        #1;
        act = a; tx = t; rx = r; cpu = c; rz = z[0]; ts = seq_idx;
        dm = {16'($urandom), 32'($urandom)};
        sm = {16'($urandom), 32'($urandom)};
        sq = 16'($urandom);
        cf = z[1] ? 32'hffffffff : 32'($urandom);
        rt = $urandom;
        st = $urandom;
        m = c ? cpucfg : pdm[t];
        e = '{dm, sm, sq, cf, m, 3'h0};
        if (a[1:0] != 2'h0 && z[0]) rsv_e = 1'b1;
        if (ena[t] && pdom[t] === m[3:2]) begin
            case (a[3:2])
                2'h0: opt = 16'h0000;
                2'h1: opt = egr[t];
                2'h2: opt = iga[r];
                default: opt = igb[r];
            endcase
            if (a[1:0] == 2'h1 && !a[5]) begin
                sum = {1'b0, cf} + opt + txio[t];
                e.c = sum[31:0];
                if (sum[32]) ov_e[t] = 1'b1;
            end
            if (a[1:0] == 2'h1 && a[5]) e.c = rt - rxio[r];
            if (a[1:0] == 2'h2) stq.push_back(st);
            if (a[5:4] == 2'h1) begin
                e.q = tbl[ts];
                tbl[ts] = tbl[ts] + 16'h0001;
            end
            if (a[6]) e.d = sm;
            if (a[7]) e.s = {hi[t], lo[t]};
            e.f = {!ck[t] && (a[1:0] == 2'h1 ||
                   a[5:4] == 2'h1 || a[7:6] != 2'h0), a[5],
                   a[1:0] == 2'h3};
        end
        ex.push_back(e);
        fv = 1'b1;
        while (fr !== 1'b1) @(posedge clk) #1;
        @(posedge clk);
        #1;
        fv = 1'b0;
    endtask : send
    task automatic drain();
        for (int k = 0; k < 300 && ex.size() != 0; k++) @(posedge clk);
        repeat (3) @(posedge clk);
        #1;
        if (ex.size() != 0)
            chk("drain timeout", 64'h0, 64'(ex.size()));
        $display("test step done");
    endtask : drain
    ////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (!rst && ov === 1'b1 && ordy === 1'b1) begin
            if (ex.size() == 0) begin
                chk("extra record", 64'h0, 64'h1);
            end else begin
                me = ex.pop_front();
                chk("dmac", 64'(me.d), 64'(od));
                chk("smac", 64'(me.s), 64'(os));
                chk("seq", 64'(me.q), 64'(oq));
                chk("cf", 64'(me.c), 64'(oc));
                chk("domain mode", 64'(me.m), 64'(odm));
                chk("flags", 64'(me.f), 64'(of));
            end
        end
    end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #400000;
        err_count++;
        end_of_test();
    end
    initial begin
        void'($urandom(61365));
        rst = 1; fv = 0; act = 0; tx = 0; rx = 0; cpu = 0; rz = 0; ts = 0;
        dm = 0; sm = 0; sq = 0; cf = 0; rt = 0; st = 0; stall = 0;
        seq_wr = 0; seq_idx = 0; seq_wd = 0; spop = 0; rclr = 0; ovclr = 0;
        rsv_e = 0; ov_e = 0; err_count = 0; total_checks = 0;
        dom = 2'($urandom);
        dv = $urandom % 8;
        for (i = 0; i < 256; i++) tbl[i] = 16'h0000;
        for (i = 0; i < 4; i++) begin
            egr[i] = 16'($urandom); iga[i] = 16'($urandom);
            igb[i] = 16'($urandom); txio[i] = 16'(1 + $urandom % 200);
            lo[i] = $urandom; hi[i] = 16'($urandom);
            pdm[i] = {dom, 2'($urandom)}; pdom[i] = dom;
            ck[i] = i[0]; ena[i] = 1'b1;
        end
        pdom[3] = dom + 2'h1;
        cpucfg = {dom, 2'($urandom)};
        // Link is up before any frame, so delays are final here
        rxio[0] = 16'(63 + 8 * dv / 10);
        rxio[1] = 16'(31 + 32 * dv / 100);
        rxio[2] = 16'(84 - 8 * dv / 10);
        rxio[3] = 16'(87);
        repeat (5) @(posedge clk);
        #1;
        rst = 0;
        chk("table reset", 64'h0, 64'(seq_rd));
        for (i = 0; i < 16; i++) send({4'h0, 2'(i), 2'(i >> 2)},
            2'($urandom % 3), 2'($urandom), i[0], 2'h0);
        send(8'h21, 2'h0, 2'h1, 1'b0, 2'h0);
        send(8'h31, 2'h1, 2'h2, 1'b0, 2'h0);
        drain();
        seq_idx = 8'h05; seq_wd = 16'($urandom); seq_wr = 1;
        tbl[5] = seq_wd;
        @(posedge clk);
        #1;
        seq_wr = 0;
        send(8'h10, 2'h0, 2'h0, 1'b0, 2'h0);
        send(8'h10, 2'h1, 2'h0, 1'b0, 2'h0);
        repeat (2) @(posedge clk);
        #1;
        chk("table entry", 64'(tbl[5]), 64'(seq_rd));
        send(8'h40, 2'h2, 2'h0, 1'b0, 2'h0);
        send(8'hc0, 2'h1, 2'h0, 1'b0, 2'h0);
        send(8'h43, 2'h0, 2'h0, 1'b0, 2'h0);
        send(8'h06, 2'h0, 2'h0, 1'b0, 2'h0);
        send(8'h0a, 2'h2, 2'h1, 1'b0, 2'h0);
        send(8'hd1, 2'h3, 2'h0, 1'b0, 2'h1);
        send(8'h01, 2'h2, 2'h0, 1'b0, 2'h2);
        drain();
        while (stq.size() != 0) begin
            chk("stamp valid", 64'h1, 64'(svld));
            chk("stamp value", 64'(stq.pop_front()), 64'(sval));
            spop = 1;
            @(posedge clk);
            #1;
            spop = 0;
            repeat (3) @(posedge clk);
            #1;
        end
        chk("stamp empty", 64'h0, 64'(svld));
        chk("stamp drop", 64'h0, 64'(sdrop));
        send(8'h01, 2'h0, 2'h0, 1'b0, 2'h0);
        drain();
        chk("reserved sticky", 64'(rsv_e), 64'(rsts));
        chk("overflow sticky", 64'(ov_e), 64'(ovs));
        rclr = 1; ovclr = 4'hf;
        @(posedge clk);
        #1;
        rclr = 0; ovclr = 0;
        @(posedge clk);
        #1;
        chk("sticky clear", 64'h0, 64'({rsts, ovs}));
        stall = 1;
        for (i = 0; i < 9; i++) send(8'h00, 2'h0, 2'h1, 1'b0, 2'h0);
        repeat (4) @(posedge clk);
        #1;
        chk("queue full ready", 64'h0, 64'(fr));
        stall = 0;
        drain();
        chk("queue empty", 64'h0, 64'(ov));
        end_of_test();
    end
endmodule : pfr_rewriter_tb_top
`default_nettype wire
